// file: mpd_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH
`define MPD_IDX_CH1     6'h02
`define MPD_IDX_CH6     6'h07
`define MPD_IDX_OUTCTL  6'h08
`define MPD_IDX_GPWM    6'h09
`define MPD_IDX_INEN    6'h0b
`define MPD_IDX_INCR    6'h0e
`define MPD_IDX_PSF     6'h10
`define MPD_IDX_STAT    6'h11
`define MPD_CH_ON_BIT   8
`define MPD_GDUTY_LSB   8
`define MPD_SIGN_BIT    16
`define MPD_FAIL_LSB    8
`define MPD_DUTY_RST    8'h00
`define MPD_DUTY_MAX    8'hff
`define MPD_DUTY_SKIPLO 8'hf7
`define MPD_STEP_01     8'h04
`define MPD_STEP_10     8'h08
`define MPD_STEP_11     8'h10
`define MPD_CLK_NS      20
`define MPD_DGL_NS      160
`define MPD_DGL_CYC     ((`MPD_DGL_NS + `MPD_CLK_NS - 1) / `MPD_CLK_NS)
`define MPD_RESP_OKAY   2'b00
`define MPD_RESP_SLVERR 2'b10
`endif

// file: mpd_pkg.sv
// Shared types of the duty select block
`default_nettype none
package mpd_pkg;
  typedef logic [7:0] mpd_duty_t;   // One duty value
  typedef logic [1:0] mpd_code_t;   // Two-bit code field
  typedef logic [5:0] mpd_idx_t;    // Register word index
endpackage
`default_nettype wire

// file: mpd_top.sv
// Duty select of six channels, step adjust and pulse skip of five, input gating of four
`timescale 1ns/100ps
`default_nettype none
`include "mpd_defines.svh"
module mpd_top #(
  parameter int DGL_CYCLES = `MPD_DGL_CYC  // Deglitch hold, cycles
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic [3:0]        control_input_pin_i,
  input  wire logic [3:0]        window_trigger_i,
  input  wire logic              fail_mode_i,
  input  wire logic              pwm_period_i,
  output logic [5:0]             channel_drive_o,
  output logic [5:0][7:0]        duty_value_o,
  output logic [4:0]             ocw_start_o,
  output logic                   external_channel_output_o,
  output logic [3:0]             filtered_input_o
);

  // Whole block state in one record
  typedef struct packed {
    logic [5:0][7:0] duty;      // Individual duty values
    logic [5:0]      on;        // Channel on bits
    logic [5:0]      gsel;      // Global duty select bits
    logic [7:0]      gduty;     // Shared global duty
    logic [3:0][1:0] inen;      // Input enable codes
    logic            sign;      // Last step direction
    logic [4:0][1:0] step;      // Last step codes
    logic [4:0]      pulse_skip_enable;       // Pulse skip enables
    logic [3:0]      filt;      // Deglitched inputs
    logic [3:0][7:0] dcnt;      // Deglitch counters
    logic [3:0]      trig;      // Trigger history
    logic [2:0]      frame;     // Skip frame state
    logic [5:0]      drive;     // Channel drive
    logic [4:0]      ocw;       // Window start pulses
    logic [5:0][7:0] dout;      // Effective duty
    logic            aw_have;   // Write address held
    logic [5:0]      aw_idx;    // Held write index
    logic            w_have;    // Write data held
    logic [31:0]     wdata;     // Held write data
    logic [3:0]      wstrb;     // Held byte enables
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } mpd_state_s;

  mpd_state_s q;   // Registered state
  mpd_state_s d;   // Next state

  // Word index is mapped to a register
  function automatic logic mapped(input mpd_pkg::mpd_idx_t idx);
    mapped = (idx >= `MPD_IDX_CH1 && idx <= `MPD_IDX_GPWM) ||
             idx == `MPD_IDX_INEN || idx == `MPD_IDX_INCR ||
             idx == `MPD_IDX_PSF || idx == `MPD_IDX_STAT;
  endfunction

  // Read-back value, also the base of partial writes
  function automatic logic [31:0] rd(input mpd_state_s s,
                                     input mpd_pkg::mpd_idx_t idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int k = 0; k < 6; k++)
    begin
      if (idx == `MPD_IDX_CH1 + 6'(k))
      begin
        v[7:0] = s.duty[k];
        v[`MPD_CH_ON_BIT] = s.on[k];
      end
    end
    if (idx == `MPD_IDX_OUTCTL)
      v[5:0] = s.on;
    if (idx == `MPD_IDX_GPWM)
    begin
      v[5:0] = s.gsel;
      v[`MPD_GDUTY_LSB +: 8] = s.gduty;
    end
    if (idx == `MPD_IDX_INEN)
      v[7:0] = s.inen;
    if (idx == `MPD_IDX_INCR)
    begin
      v[9:0] = s.step;
      v[`MPD_SIGN_BIT] = s.sign;
    end
    if (idx == `MPD_IDX_PSF)
      v[4:0] = s.pulse_skip_enable;
    if (idx == `MPD_IDX_STAT)
    begin
      v[5:0] = s.drive;
      v[`MPD_FAIL_LSB +: 4] = s.filt;
    end
    rd = v;
  endfunction

  // Step magnitude from code
  function automatic mpd_pkg::mpd_duty_t step_amt(input mpd_pkg::mpd_code_t c);
    unique case (c)
      2'b00:   step_amt = 8'h00;
      2'b01:   step_amt = `MPD_STEP_01;
      2'b10:   step_amt = `MPD_STEP_10;
      2'b11:   step_amt = `MPD_STEP_11;
    endcase
  endfunction

  // Saturating step, never wraps
  function automatic mpd_pkg::mpd_duty_t sat_step(input mpd_pkg::mpd_duty_t v,
                                                  input mpd_pkg::mpd_duty_t a,
                                                  input logic inc);
    logic [8:0] sum;
    sum = {1'b0, v} + {1'b0, a};
    if (inc)
      sat_step = sum[8] ? `MPD_DUTY_MAX : sum[7:0];
    else
      sat_step = (v < a) ? `MPD_DUTY_RST : 8'(v - a);
  endfunction

  // Next-state logic of the whole block
  always_comb
  begin
    logic [31:0] wv;
    logic [3:0]  m;
    logic        sel;
    logic        gate;
    logic [7:0]  dsel;
    logic [2:0]  gap;
    wv   = 32'h0000_0000;
    m    = 4'h0;
    sel  = 1'b0;
    gate = 1'b0;
    dsel = 8'h00;
    gap  = 3'h0;
    d = q;

    // Deglitch: output moves only after a steady input
    for (int i = 0; i < 4; i++)
    begin
      if (control_input_pin_i[i] == q.filt[i])
        d.dcnt[i] = 8'h00;
      else if (q.dcnt[i] >= 8'(DGL_CYCLES - 1))
      begin
        d.filt[i] = control_input_pin_i[i];
        d.dcnt[i] = 8'h00;
      end
      else
        d.dcnt[i] = q.dcnt[i] + 8'h01;
    end

    // Skip frame advances once per PWM period
    if (pwm_period_i)
      d.frame = q.frame + 3'h1;

    // Channel gating and duty selection
    for (int i = 0; i < 6; i++)
    begin
      sel  = q.gsel[i];
      gate = 1'b1;
      if (i < 4)
      begin
        unique case (q.inen[i % 4])
          2'b00:   gate = 1'b1;
          2'b01:   gate = q.filt[i % 4];
          2'b10:   gate = q.filt[i % 4];
          2'b11:   sel  = q.gsel[i] ^ q.filt[i % 4];
        endcase
      end
      if (fail_mode_i)
        d.drive[i] = (i < 4) ? q.filt[i % 4] : 1'b0;
      else
        d.drive[i] = q.on[i] & gate;
      dsel = sel ? q.gduty : q.duty[i];
      // Pulse skipping only at the top end, per own channel bit
      gap = 3'(`MPD_DUTY_MAX - dsel);
      if (i < 5 && q.pulse_skip_enable[i % 5] && dsel > `MPD_DUTY_SKIPLO &&
          dsel < `MPD_DUTY_MAX)
      begin
        // Bit-reversed frame spreads the short periods evenly
        if ({q.frame[0], q.frame[1], q.frame[2]} < gap)
          d.dout[i] = `MPD_DUTY_SKIPLO;
        else
          d.dout[i] = `MPD_DUTY_MAX;
      end
      else
        d.dout[i] = dsel;
    end

    // Window start: rising drive, or trigger edge in fail mode
    d.trig = window_trigger_i;
    if (fail_mode_i)
      d.ocw = {1'b0, window_trigger_i & ~q.trig};
    else
      d.ocw = d.drive[4:0] & ~q.drive[4:0];

    // Write address and data are taken independently
    if (q.awready && s_axi_awvalid_i)
    begin
      d.aw_have = 1'b1;
      d.aw_idx  = s_axi_awaddr_i[7:2];
    end
    if (q.wready && s_axi_wvalid_i)
    begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata_i;
      d.wstrb  = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i)
      d.bvalid = 1'b0;

    // Commit once both halves are held and no response waits
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      for (int b = 0; b < 4; b++)
        m[b] = q.wstrb[b];
      wv = rd(q, q.aw_idx);
      for (int b = 0; b < 4; b++)
      begin
        if (m[b])
          wv[8*b +: 8] = q.wdata[8*b +: 8];
      end
      for (int k = 0; k < 6; k++)
      begin
        if (q.aw_idx == `MPD_IDX_CH1 + 6'(k))
        begin
          d.duty[k] = wv[7:0];
          d.on[k]   = wv[`MPD_CH_ON_BIT];
        end
      end
      if (q.aw_idx == `MPD_IDX_OUTCTL)
        d.on = wv[5:0];
      if (q.aw_idx == `MPD_IDX_GPWM)
      begin
        d.gsel  = wv[5:0];
        d.gduty = wv[`MPD_GDUTY_LSB +: 8];
      end
      if (q.aw_idx == `MPD_IDX_INEN)
        d.inen = wv[7:0];
      if (q.aw_idx == `MPD_IDX_INCR)
      begin
        d.step = wv[9:0];
        d.sign = wv[`MPD_SIGN_BIT];
        // Only channels one to five move; global and six stay
        for (int k = 0; k < 5; k++)
          d.duty[k] = sat_step(q.duty[k], step_amt(wv[2*k +: 2]),
                               wv[`MPD_SIGN_BIT]);
      end
      if (q.aw_idx == `MPD_IDX_PSF)
        d.pulse_skip_enable = wv[4:0];
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      // Status word is read-only, so writes to it are refused too
      if (mapped(q.aw_idx) && q.aw_idx != `MPD_IDX_STAT)
        d.bresp = `MPD_RESP_OKAY;
      else
        d.bresp = `MPD_RESP_SLVERR;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // Read channel: one word at a time
    if (q.rvalid && s_axi_rready_i)
      d.rvalid = 1'b0;
    if (q.arready && s_axi_arvalid_i)
    begin
      d.rvalid = 1'b1;
      d.rdata  = rd(q, s_axi_araddr_i[7:2]);
      if (mapped(s_axi_araddr_i[7:2]))
        d.rresp = `MPD_RESP_OKAY;
      else
        d.rresp = `MPD_RESP_SLVERR;
    end
    d.arready = !d.rvalid;

    // Clock enable low freezes everything
    if (!ce_i)
      d = q;
  end

  // State register, all fields reset to zero
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign s_axi_awready_o  = q.awready;
  assign s_axi_wready_o   = q.wready;
  assign s_axi_bvalid_o   = q.bvalid;
  assign s_axi_bresp_o    = q.bresp;
  assign s_axi_arready_o  = q.arready;
  assign s_axi_rvalid_o   = q.rvalid;
  assign s_axi_rdata_o    = q.rdata;
  assign s_axi_rresp_o    = q.rresp;
  assign channel_drive_o  = q.drive;
  assign duty_value_o     = q.dout;
  assign ocw_start_o      = q.ocw;
  assign filtered_input_o = q.filt;
  assign external_channel_output_o = q.drive[5];

  // Checks on the registered behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  a_off_when_clear: assert property (
    ce_i && !fail_mode_i |=> (q.drive & ~$past(q.on)) == 6'h00)
    else $error("drive on while on bit clear");
  a_fail_five_six: assert property (
    ce_i && fail_mode_i |=> q.drive[5:4] == 2'b00)
    else $error("channel five or six on in fail mode");
  a_fail_follow: assert property (
    ce_i && fail_mode_i |=> q.drive[3:0] == $past(q.filt))
    else $error("fail mode drive not following input");
  a_window_rise: assert property (
    $past(ce_i) && !$past(fail_mode_i) |->
    q.ocw == (q.drive[4:0] & ~$past(q.drive[4:0])))
    else $error("window start not on rising drive");
  a_step_keeps: assert property (
    ce_i && q.aw_have && q.w_have && !q.bvalid &&
    q.aw_idx == `MPD_IDX_INCR |=>
    $stable(q.gduty) && $stable(q.duty[5]))
    else $error("step changed global or channel six");
  a_step_up_sat: assert property (
    ce_i && q.aw_have && q.w_have && !q.bvalid &&
    q.aw_idx == `MPD_IDX_INCR && q.wdata[`MPD_SIGN_BIT] &&
    q.wstrb == 4'hf && q.wdata[1:0] != 2'b00 |=>
    q.duty[0] >= $past(q.duty[0]))
    else $error("increment wrapped");
  a_skip_levels: assert property (
    $past(ce_i) && $past(q.pulse_skip_enable[0]) |->
    !(q.dout[0] inside {[8'hf8:8'hfe]}))
    else $error("skip channel shows interpolated duty");
  a_deglitch_hold: assert property (
    q.filt[0] != $past(q.filt[0]) |->
    $past(control_input_pin_i[0], 1) == q.filt[0] &&
    $past(control_input_pin_i[0], 2) == q.filt[0])
    else $error("filtered input moved on a glitch");
  a_bvalid_hold: assert property (
    q.bvalid && !s_axi_bready_i |=> q.bvalid)
    else $error("write response dropped");
  a_rvalid_hold: assert property (
    q.rvalid && !s_axi_rready_i |=> q.rvalid && $stable(q.rdata))
    else $error("read response dropped");

  c_step_write: cover property (
    q.aw_have && q.w_have && q.aw_idx == `MPD_IDX_INCR);
  c_skip_low: cover property (q.dout[0] == `MPD_DUTY_SKIPLO);
  c_fail_trig: cover property (fail_mode_i && q.ocw[0]);
  c_swap_duty: cover property (q.inen[0] == 2'b11 && q.filt[0]);

endmodule
`default_nettype wire

// file: mpd_axi_master.sv
// Register bus master standing in for the controlling processor
`timescale 1ns/100ps
`default_nettype none
module mpd_axi_master (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // Idle bus from time zero
  initial
  begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  // One write; a taken channel is dropped and its payload inverted, never left stale
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {awaddr_o, awvalid_o} <= {a, 1'b1};
    {wdata_o, wvalid_o, bready_o} <= {d, 2'b11};
    do
    begin
      @(posedge clk_i);
      if (awready_i & awvalid_o) {awaddr_o, awvalid_o} <= {~awaddr_o, 1'b0};
      if (wready_i & wvalid_o) {wdata_o, wvalid_o} <= {~wdata_o, 1'b0};
    end
    while (!bvalid_i);
    bready_o <= 1'b0;
  endtask
  // One read; ready held until the answer is sampled
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'b11};
    do
    begin
      @(posedge clk_i);
      if (arready_i & arvalid_o) {araddr_o, arvalid_o} <= {~araddr_o, 1'b0};
    end
    while (!rvalid_i);
    rready_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test_multichannel_pwm_duty_select.sv
// Self-checking bench of the duty select block
`timescale 1ns/100ps
`default_nettype none
`include "mpd_defines.svh"
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module test_multichannel_pwm_duty_select;
  localparam int DGL = 2;  // Short deglitch keeps the run brief
  logic            clk_sys_i, sys_rst_i, fail_mode, pwm_period;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  logic [7:0]      awaddr, araddr, d;
  logic [31:0]     wdata, rdata, lfsr;
  logic [1:0]      bresp, rresp;
  logic [3:0]      pins, filt;
  logic [5:0]      drive;
  logic [4:0]      ocw;
  logic [5:0][7:0] duty_w;
  logic [7:0]      duty[6];   // Stored duty model
  logic [33:0]     got;
  logic [33:0]     exp_q[$];  // Expected response and word, oldest first
  logic [1:0]      bexp_q[$]; // Expected write responses, oldest first
  logic [1:0]      bgot;      // Oldest expected write response
  logic            ce;        // Clock enable to the block
  logic            ext_out;   // External channel drive
  logic [3:0]      trig;      // Fail mode window triggers
  int              fail_count, n_tests, ocw_n, k;
  int              cnt[3];
  mpd_top #(.DGL_CYCLES(DGL)) dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .control_input_pin_i(pins),
    .window_trigger_i(trig), .fail_mode_i(fail_mode), .pwm_period_i(pwm_period),
    .channel_drive_o(drive), .duty_value_o(duty_w), .ocw_start_o(ocw),
    .external_channel_output_o(ext_out), .filtered_input_o(filt)
  );
  mpd_axi_master bfm_u (
    .clk_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rvalid_i(rvalid), .rready_o(rready)
  );
  // Free-running system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Next random word
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Saturating step of one duty value
  function automatic logic [7:0] step(input logic [7:0] v, input logic [1:0] c,
                                      input logic up);
    int r;
    r = (c == 2'b00) ? 0 : 2 << c;
    r = up ? int'(v) + r : int'(v) - r;
    return (r < 0) ? 8'h00 : (r > 255) ? 8'hff : 8'(r);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Register write by word index, expected response noted first
  task automatic wr(input int i, input logic [31:0] v, input logic [1:0] r = `MPD_RESP_OKAY);
    bexp_q.push_back(r);
    bfm_u.wr(8'(i * 4), v);
  endtask
  // Note the expected answer, then read
  task automatic rdc(input int i, input logic [31:0] e, input logic [1:0] r = `MPD_RESP_OKAY);
    exp_q.push_back({r, e});
    bfm_u.rd(8'(i * 4));
  endtask
  // One reference period strobe, then settle
  task automatic pulse();
    pwm_period <= 1'b1;
    cyc(1);
    pwm_period <= 1'b0;
    cyc(3);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Read answers against oldest note; window starts counted
  always @(posedge clk_sys_i)
  begin
    if ((rvalid & rready) === 1'b1)
    begin
      got = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK({rresp, rdata}, got)
    end
    if ((bvalid & bready) === 1'b1)
    begin
      bgot = (bexp_q.size() > 0) ? bexp_q.pop_front() : 2'bxx;
      `CHK(bresp, bgot)
    end
    ocw_n += $countones(ocw);
  end
  // Hang guard
  initial
  begin
    cyc(20000);
    fail_count++;
    stop_test();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    pins = 4'h0;
    fail_mode = 1'b0;
    pwm_period = 1'b0;
    ce = 1'b1;
    trig = 4'h0;
    lfsr = 32'h850a;
    cyc(4);
    sys_rst_i <= 1'b0;
    // Reset state, then an unmapped word
    for (int i = 2; i <= 9; i++)
      rdc(i, 32'h0);
    rdc(16, 32'h0);
    rdc(1, 32'h0, `MPD_RESP_SLVERR);
    // Random duties near both rails, then one stepping write
    for (int it = 0; it < 6; it++)
    begin
      for (int c = 0; c < 6; c++)
      begin
        lfsr = nxt(lfsr);
        duty[c] = (c == 0) ? {4'h0, lfsr[3:0]} : (c == 1) ? {4'hf, lfsr[3:0]} : lfsr[7:0];
        wr(2 + c, {24'h0, duty[c]});
      end
      d = lfsr[15:8];
      wr(9, {16'h0, d, 8'h00});
      lfsr = nxt(lfsr);
      wr(14, {15'h0, lfsr[16:0]});
      for (int c = 0; c < 5; c++)
        duty[c] = step(duty[c], lfsr[2 * c +: 2], lfsr[16]);
      for (int c = 0; c < 6; c++)
        rdc(2 + c, {24'h0, duty[c]});
      rdc(9, {16'h0, d, 8'h00});
    end
    // Channel one on global duty
    wr(2, 32'h40);
    wr(9, 32'h9001);
    cyc(2);
    `CHK(duty_w[0], 8'h90)
    `CHK(duty_w[1], duty[1])
    // Skip pattern per duty; last pass has skipping off
    wr(16, 32'h3f);
    for (int i = 0; i < 10; i++)
    begin
      d = (i == 8) ? 8'h03 : (i == 9) ? 8'hfe : 8'hf8 + 8'(i);
      if (i == 9)
        wr(16, 32'h0);
      wr(3, {24'h0, d});
      wr(7, {24'h0, d});
      wr(9, {16'h0, d, 8'h01});
      cnt = '{0, 0, 0};
      repeat (8)
      begin
        pulse();
        cnt[0] += (duty_w[0] === 8'hf7);
        cnt[1] += (duty_w[1] === 8'hf7);
        cnt[2] += (duty_w[5] !== d);
      end
      k = (i >= 8) ? 0 : 7 - i;
      `CHK(cnt[1], k)
      `CHK(cnt[0], k)
      `CHK(cnt[2], 0)
    end
    // Input gating codes 00, 01, 10, 11 on channels one to four
    wr(5, 32'h22);
    wr(11, 32'he4);
    ocw_n = 0;
    wr(8, 32'h3f);
    rdc(17, 32'h39);
    `CHK(ext_out, 1'b1)
    `CHK(duty_w[3], 8'h22)
    pins <= 4'hf;
    cyc(DGL + 4);
    rdc(17, 32'hf3f);
    `CHK(duty_w[3], 8'hfe)
    `CHK(ocw_n, 5)
    // Short dip must not pass the filter
    pins <= 4'h0;
    cyc(DGL - 1);
    pins <= 4'hf;
    cyc(DGL + 4);
    rdc(17, 32'hf3f);
    `CHK(ocw_n, 5)
    // Fail mode follows the filtered inputs
    fail_mode <= 1'b1;
    pins <= 4'h5;
    cyc(DGL + 4);
    rdc(17, 32'h505);
    `CHK(ext_out, 1'b0)
    // Trigger edges start windows in fail mode
    ocw_n = 0;
    trig <= 4'h9;
    cyc(3);
    trig <= 4'h0;
    cyc(2);
    `CHK(ocw_n, 2)
    // On bits clear force all drives off
    fail_mode <= 1'b0;
    pins <= 4'hf;
    wr(8, 32'h0);
    cyc(DGL + 4);
    rdc(17, 32'hf00);
    // Status and unmapped words refuse writes
    wr(17, 32'h0, `MPD_RESP_SLVERR);
    wr(1, 32'hffff, `MPD_RESP_SLVERR);
    rdc(17, 32'hf00);
    // Clock enable low freezes the filter
    ce <= 1'b0;
    pins <= 4'h0;
    cyc(DGL + 4);
    `CHK(filt, 4'hf)
    ce <= 1'b1;
    cyc(DGL + 4);
    `CHK(filt, 4'h0)
    cyc(2);
    stop_test();
  end
endmodule
`default_nettype wire
